// ==== sonar_link_pkg.sv ====
`default_nettype none
package sonar_link_pkg;
   // Link clock and bit timing.
   localparam int unsigned ClkHz       = 125000000;
   localparam int unsigned BaudCurrent = 19200;
   localparam int unsigned BaudLegacy  = 115200;
   localparam int unsigned BitCycCur   = ClkHz / BaudCurrent;
   localparam int unsigned BitCycOld   = ClkHz / BaudLegacy;
   localparam int unsigned BitCntW     = 16;
   // Measurement settle time and power-up blink timing.
   localparam int unsigned MeasValidMs = 30;
   localparam int unsigned MeasCyc     = (ClkHz / 1000) * MeasValidMs;
   localparam int unsigned BlinkMs     = 100;
   localparam int unsigned BlinkCyc    = (ClkHz / 1000) * BlinkMs;
   localparam int unsigned BlinkCount  = 4;
   // Frame layout.
   localparam logic [7:0] HdrFirst     = 8'h55;
   localparam logic [7:0] HdrSecond    = 8'haa;
   localparam logic [7:0] CmdSetAddr   = 8'h55;
   localparam logic [7:0] CmdTrigger   = 8'h01;
   localparam logic [7:0] CmdReadDist  = 8'h02;
   localparam logic [7:0] CmdReadTemp  = 8'h03;
   localparam logic [7:0] AddrDefault  = 8'h11;
   localparam logic [7:0] AddrMin      = 8'h11;
   localparam logic [7:0] AddrMax      = 8'h80;
   localparam logic [7:0] StatusOk     = 8'h01;
   localparam logic [7:0] InvalidByte  = 8'hff;
   localparam logic [7:0] MaxPayload   = 8'h02;
   // Low eight bits of the sum of all preceding frame bytes.
   function automatic logic [7:0] frameChecksumAdd(input logic [7:0] acc, input logic [7:0] b);
      return 8'(acc + b);
   endfunction
endpackage
`default_nettype wire

// ==== rs485_link_if.sv ====
`default_nettype none
interface rs485_link_if;
   // Each end drives the shared pair only while its enable is high.
   logic slaveTx;
   logic slaveTxEn;
   logic masterTx;
   logic masterTxEn;
   // Resolved line: idle is mark (high) when nobody drives.
   wire  line = slaveTxEn ? slaveTx : (masterTxEn ? masterTx : 1'b1);
   modport slave  (input line, output slaveTx, output slaveTxEn);
   modport master (input line, output masterTx, output masterTxEn);
endinterface
`default_nettype wire

// ==== sonar_slave.sv ====
// Functional notes
// - Link runs 19200 baud, 8N1.
// - Legacy variant runs 115200 baud instead.
// - Frame: 55 aa addr len cmd payload checksum.
// - Set-address cmd 55, new address 0x11..0x80.
// - Set-address reply from new address, status 01.
// - Failed address change sends no reply.
// - Default bus address is 0x11.
// - Trigger cmd 01 starts measurement, no reply.
// - Result valid 30 ms after trigger.
// - Read distance replies 02, two bytes, high first.
// - Failed measurement reads as ff ff.
// - Distance is unsigned centimetres, 4..300.
// - Read temperature replies 03, two bytes.
// - Top nibble of high byte is sign.
// - Remaining twelve bits are 0.1 C magnitude.
// - Invalid temperature reads as ff ff.
// - LED blinks four times at power-up, and on traffic.
// - Transmitter released when idle and after reply.
// - Only the master starts transactions.
`default_nettype none
module sonar_slave
   import sonar_link_pkg::*;
#(
   parameter bit LegacyBaud = 1'b0,
   // Cycles per bit; follows the rate choice unless a shorter one is forced.
   parameter int unsigned BitLen = LegacyBaud ? BitCycOld : BitCycCur,
   parameter int unsigned MeasWait = MeasCyc,
   parameter int unsigned BlinkLen = BlinkCyc
) (
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Bus pair.
   rs485_link_if.slave      link,
   // Measurement front end.
   output logic             measStart,
   input  wire logic        measDone,
   input  wire logic        measOk,
   input  wire logic [8:0]  measCm,
   input  wire logic        tempOk,
   input  wire logic [15:0] tempCode,
   // Status.
   output logic             commLed,
   output logic [7:0]       nodeAddr
);
   // Receiver and transmitter share one bit period chosen at build time.
   localparam logic [BitCntW-1:0] BitCyc  = BitCntW'(BitLen);
   localparam logic [BitCntW-1:0] HalfCyc = BitCntW'(BitLen / 2);

   typedef enum logic [2:0] {RxHdr1 = 3'b000, RxHdr2 = 3'b001, RxAddr = 3'b011, RxLen = 3'b010,
                             RxCmd = 3'b110, RxData = 3'b111, RxSum = 3'b101} rx_state_type;

   // Byte receiver state.
   logic [BitCntW-1:0] rxCnt_q;     // Cycles into current bit.
   logic [3:0]         rxBit_q;     // Bit index, 0 is start bit.
   logic               rxBusy_q;    // Receiving a character.
   logic [7:0]         rxSh_q;      // Incoming shift register.
   logic               rxStrobe_q;  // One-cycle byte-ready pulse.
   logic               lineD_q;     // Previous line level for start-edge detection.
   // Frame parser state.
   rx_state_type       pst_q;
   logic [7:0]         sum_q;       // Running checksum.
   logic [7:0]         len_q;
   logic [7:0]         cmd_q;
   logic [7:0]         arg_q;       // First payload byte.
   logic [1:0]         idx_q;
   logic               forMe_q;
   // Measurement results.
   logic [15:0]        dist_q;
   logic [23:0]        measTmr_q;
   // Reply transmitter.
   logic [7:0]         txBuf_q [0:7];
   logic [2:0]         txLen_q;
   logic [2:0]         txIdx_q;
   logic               txBusy_q;
   logic               txWait_q;    // Reply loaded, waiting for the master to let go.
   logic [3:0]         txBit_q;
   logic [BitCntW-1:0] txCnt_q;
   logic               txLine_q;
   // Indicator.
   logic [3:0]         blinks_q;
   logic [27:0]        ledTmr_q;
   logic               led_q;

   // Start bit: falling edge of an idle line while we are not talking.
   wire logic rxStart = !rxBusy_q && lineD_q && !link.line && !txBusy_q;
   wire logic bitMid  = rxBusy_q && (rxCnt_q == ((rxBit_q == 4'd0) ? HalfCyc : BitCyc - BitCntW'(1)));

   // Character receiver samples mid-bit, shifting LSB first.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxCnt_q <= '0; rxBit_q <= '0; rxBusy_q <= 1'b0; rxSh_q <= '0;
         rxStrobe_q <= 1'b0; lineD_q <= 1'b1;
      end else begin
         lineD_q    <= link.line;
         rxStrobe_q <= 1'b0;
         if (rxStart) begin
            rxBusy_q <= 1'b1; rxCnt_q <= '0; rxBit_q <= '0;
         end else if (bitMid) begin
            rxCnt_q <= '0;
            rxBit_q <= rxBit_q + 4'd1;
            if (rxBit_q == 4'd0 && link.line) begin
               rxBusy_q <= 1'b0;                      // Glitch, not a start bit.
            end else if (rxBit_q == 4'd9) begin
               rxBusy_q   <= 1'b0;
               rxStrobe_q <= link.line;               // Framing error drops the byte.
            end else if (rxBit_q != 4'd0) begin
               rxSh_q <= {link.line, rxSh_q[7:1]};
            end
         end else if (rxBusy_q) begin
            rxCnt_q <= rxCnt_q + BitCntW'(1);
         end
      end
   end

   wire logic [7:0] rxByte = rxSh_q;
   wire logic [7:0] sumNext = frameChecksumAdd(sum_q, rxByte);
   wire logic frameGood = rxStrobe_q && pst_q == RxSum && forMe_q && rxByte == sum_q;
   wire logic addrOk = arg_q >= AddrMin && arg_q <= AddrMax;
   wire logic doSet  = frameGood && cmd_q == CmdSetAddr && len_q == 8'd1 && addrOk;
   wire logic doTrig = frameGood && cmd_q == CmdTrigger && len_q == 8'd0;
   wire logic doDist = frameGood && cmd_q == CmdReadDist && len_q == 8'd0;
   wire logic doTemp = frameGood && cmd_q == CmdReadTemp && len_q == 8'd0;
   wire logic [15:0] tempWord = tempOk ? tempCode : {InvalidByte, InvalidByte};

   // Frame parser; a bad header byte or an oversize length quietly restarts the hunt for a header.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pst_q <= RxHdr1; sum_q <= '0; len_q <= '0; cmd_q <= '0; arg_q <= '0;
         idx_q <= '0; forMe_q <= 1'b0;
      end else if (rxStrobe_q) begin
         sum_q <= sumNext;
         case (pst_q)
            RxHdr1: begin
               sum_q <= rxByte;
               pst_q <= (rxByte == HdrFirst) ? RxHdr2 : RxHdr1;
            end
            RxHdr2: pst_q <= (rxByte == HdrSecond) ? RxAddr : RxHdr1;
            RxAddr: begin
               forMe_q <= (rxByte == nodeAddr);
               pst_q   <= RxLen;
            end
            RxLen: begin
               len_q <= rxByte;
               pst_q <= (rxByte > MaxPayload) ? RxHdr1 : RxCmd;
            end
            RxCmd: begin
               cmd_q <= rxByte; idx_q <= '0;
               pst_q <= (len_q == 8'd0) ? RxSum : RxData;
            end
            RxData: begin
               if (idx_q == 2'd0) begin
                  arg_q <= rxByte;
               end
               idx_q <= idx_q + 2'd1;
               pst_q <= (8'(idx_q) + 8'd1 == len_q) ? RxSum : RxData;
            end
            default: pst_q <= RxHdr1;                             // Checksum byte ends the frame.
         endcase
      end
   end

   // Address register and measurement buffer.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nodeAddr <= AddrDefault;
         dist_q <= {InvalidByte, InvalidByte}; measTmr_q <= '0; measStart <= 1'b0;
      end else begin
         measStart <= doTrig;
         if (doSet) begin
            nodeAddr <= arg_q;
         end
         if (doTrig) begin
            measTmr_q <= 24'(MeasWait);
            dist_q    <= {InvalidByte, InvalidByte};
         end else if (measTmr_q != '0) begin
            measTmr_q <= measTmr_q - 24'd1;
            if (measDone) begin
               // Out-of-range or failed readings become ff ff; cm count otherwise.
               dist_q <= (measOk && measCm >= 9'd4 && measCm <= 9'd300) ? {7'h00, measCm}
                                                                        : {InvalidByte, InvalidByte};
            end
         end
      end
   end

   // Reply builder: header, address, length, command, payload, checksum.
   wire logic [7:0] rAddr = doSet ? arg_q : nodeAddr;
   wire logic [7:0] rLen  = doSet ? 8'd1 : 8'd2;
   wire logic [7:0] rP0   = doSet ? StatusOk : (doDist ? dist_q[15:8] : tempWord[15:8]);
   wire logic [7:0] rP1   = doDist ? dist_q[7:0] : tempWord[7:0];
   wire logic [7:0] rS1   = frameChecksumAdd(frameChecksumAdd(HdrFirst, HdrSecond), rAddr);
   wire logic [7:0] rS2   = frameChecksumAdd(frameChecksumAdd(rS1, rLen), cmd_q);
   wire logic [7:0] rS3   = frameChecksumAdd(rS2, rP0);
   wire logic [7:0] rSum  = doSet ? rS3 : frameChecksumAdd(rS3, rP1);
   wire logic replyGo     = doSet || doDist || doTemp;

   // Serial transmitter; the enable drops with the final stop bit.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txLen_q <= '0; txIdx_q <= '0; txBusy_q <= 1'b0; txBit_q <= '0;
         txCnt_q <= '0; txLine_q <= 1'b1; txWait_q <= 1'b0;
         for (int i = 0; i < 8; i++) txBuf_q[i] <= '0;
      end else if (replyGo && !txBusy_q && !txWait_q) begin
         txBuf_q[0] <= HdrFirst; txBuf_q[1] <= HdrSecond; txBuf_q[2] <= rAddr;
         txBuf_q[3] <= rLen; txBuf_q[4] <= cmd_q; txBuf_q[5] <= rP0;
         txBuf_q[6] <= doSet ? rSum : rP1; txBuf_q[7] <= rSum;
         txLen_q <= doSet ? 3'd6 : 3'd7;
         txIdx_q <= '0; txBit_q <= '0; txCnt_q <= '0; txWait_q <= 1'b1;
      end else if (txWait_q) begin
         // The checksum is taken at mid stop bit while the master still drives;
         // holding off half a bit keeps the two ends from fighting over the pair.
         if (txCnt_q == HalfCyc) begin
            txCnt_q <= '0; txWait_q <= 1'b0; txBusy_q <= 1'b1; txLine_q <= 1'b0;
         end else begin
            txCnt_q <= txCnt_q + BitCntW'(1);
         end
      end else if (txBusy_q) begin
         if (txCnt_q == BitCyc - BitCntW'(1)) begin
            txCnt_q <= '0;
            if (txBit_q == 4'd9) begin
               txBit_q <= '0;
               if (txIdx_q == txLen_q) begin
                  txBusy_q <= 1'b0;
                  txLine_q <= 1'b1;
               end else begin
                  txIdx_q  <= txIdx_q + 3'd1;
                  txLine_q <= 1'b0;
               end
            end else begin
               txBit_q  <= txBit_q + 4'd1;
               txLine_q <= (txBit_q == 4'd8) ? 1'b1 : txBuf_q[txIdx_q][txBit_q[2:0]];
            end
         end else begin
            txCnt_q <= txCnt_q + BitCntW'(1);
         end
      end
   end

   assign link.slaveTx   = txLine_q;
   assign link.slaveTxEn = txBusy_q;

   // Indicator: four blinks after reset, then one per exchanged frame that arrives while no blink is running.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         blinks_q <= 4'(BlinkCount); ledTmr_q <= '0; led_q <= 1'b0;
      end else if (ledTmr_q != '0) begin
         ledTmr_q <= ledTmr_q - 28'd1;
      end else if (blinks_q != '0) begin
         led_q    <= !led_q;
         ledTmr_q <= 28'(BlinkLen);
         if (led_q) begin
            blinks_q <= blinks_q - 4'd1;
         end
      end else if (frameGood) begin
         blinks_q <= 4'd1;
      end
   end

   assign commLed = led_q;
endmodule
`default_nettype wire

// ==== sonar_master.sv ====
`default_nettype none
module sonar_master
   import sonar_link_pkg::*;
#(
   parameter bit LegacyBaud = 1'b0,
   // Cycles per bit; follows the rate choice unless a shorter one is forced.
   parameter int unsigned BitLen = LegacyBaud ? BitCycOld : BitCycCur
) (
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Bus pair.
   rs485_link_if.master     link,
   // Command request: taken when reqValid and reqReady.
   input  wire logic        reqValid,
   output logic             reqReady,
   input  wire logic [7:0]  reqAddr,
   input  wire logic [7:0]  reqCmd,
   input  wire logic [7:0]  reqArg,
   // Received reply bytes.
   output logic             rspValid,
   output logic [7:0]       rspByte
);
   localparam logic [BitCntW-1:0] BitCyc  = BitCntW'(BitLen);
   localparam logic [BitCntW-1:0] HalfCyc = BitCntW'(BitLen / 2);

   logic [7:0]         buf_q [0:6];
   logic [2:0]         len_q, idx_q;
   logic               busy_q, line_q;
   logic [3:0]         bit_q, rBit_q;
   logic [BitCntW-1:0] cnt_q, rCnt_q;
   logic               rBusy_q, lineD_q;
   logic [7:0]         sh_q;

   // Only set-address carries a one-byte payload.
   wire logic       hasArg = reqCmd == CmdSetAddr;
   wire logic [7:0] s3 = frameChecksumAdd(frameChecksumAdd(frameChecksumAdd(HdrFirst, HdrSecond), reqAddr),
                                          hasArg ? 8'd1 : 8'd0);
   wire logic [7:0] s4 = frameChecksumAdd(s3, reqCmd);
   wire logic [7:0] s5 = frameChecksumAdd(s4, reqArg);
   assign reqReady = !busy_q;

   // Frame sender; the master alone opens transactions.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         len_q <= '0; idx_q <= '0; busy_q <= 1'b0; line_q <= 1'b1; bit_q <= '0; cnt_q <= '0;
         for (int i = 0; i < 7; i++) buf_q[i] <= '0;
      end else if (reqValid && !busy_q) begin
         buf_q[0] <= HdrFirst; buf_q[1] <= HdrSecond; buf_q[2] <= reqAddr;
         buf_q[3] <= hasArg ? 8'd1 : 8'd0; buf_q[4] <= reqCmd;
         buf_q[5] <= hasArg ? reqArg : s4; buf_q[6] <= s5;
         len_q <= hasArg ? 3'd6 : 3'd5;
         idx_q <= '0; bit_q <= '0; cnt_q <= '0; busy_q <= 1'b1; line_q <= 1'b0;
      end else if (busy_q) begin
         if (cnt_q == BitCyc - BitCntW'(1)) begin
            cnt_q <= '0;
            if (bit_q == 4'd9) begin
               bit_q <= '0;
               if (idx_q == len_q) begin
                  busy_q <= 1'b0; line_q <= 1'b1;
               end else begin
                  idx_q <= idx_q + 3'd1; line_q <= 1'b0;
               end
            end else begin
               bit_q  <= bit_q + 4'd1;
               line_q <= (bit_q == 4'd8) ? 1'b1 : buf_q[idx_q][bit_q[2:0]];
            end
         end else begin
            cnt_q <= cnt_q + BitCntW'(1);
         end
      end
   end

   assign link.masterTx   = line_q;
   assign link.masterTxEn = busy_q;

   // Reply byte receiver, raw bytes handed to the user.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rCnt_q <= '0; rBit_q <= '0; rBusy_q <= 1'b0; sh_q <= '0; lineD_q <= 1'b1;
         rspValid <= 1'b0; rspByte <= '0;
      end else begin
         lineD_q  <= link.line;
         rspValid <= 1'b0;
         if (!rBusy_q && lineD_q && !link.line && !busy_q) begin
            rBusy_q <= 1'b1; rCnt_q <= '0; rBit_q <= '0;
         end else if (rBusy_q && rCnt_q == ((rBit_q == 4'd0) ? HalfCyc : BitCyc - BitCntW'(1))) begin
            rCnt_q <= '0;
            rBit_q <= rBit_q + 4'd1;
            if (rBit_q == 4'd0 && link.line) begin
               rBusy_q <= 1'b0;
            end else if (rBit_q == 4'd9) begin
               rBusy_q  <= 1'b0;
               rspValid <= link.line;
               rspByte  <= sh_q;
            end else if (rBit_q != 4'd0) begin
               sh_q <= {link.line, sh_q[7:1]};
            end
         end else if (rBusy_q) begin
            rCnt_q <= rCnt_q + BitCntW'(1);
         end
      end
   end
endmodule
`default_nettype wire

// ==== sonar_link_sva.sv ====
`default_nettype none
module sonar_link_sva
   import sonar_link_pkg::*;
#(
   parameter bit LegacyBaud = 1'b0,
   parameter int unsigned BitLen = LegacyBaud ? BitCycOld : BitCycCur
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Shared pair as seen by both ends.
   input wire logic line,
   input wire logic slaveTx,
   input wire logic slaveTxEn,
   input wire logic masterTx,
   input wire logic masterTxEn
);
   localparam int BitCyc = int'(BitLen); // Cycles per bit.
   localparam logic [19:0] Len7 = 20'(70 * BitCyc);            // Seven-byte reply.
   localparam logic [19:0] Len8 = 20'(80 * BitCyc);            // Eight-byte reply.
   logic [19:0] txCnt_q;                                        // Cycles since the slave took the pair.
   logic [10:0] idleCnt_q;                                      // Cycles since the master let go.
   wire  [19:0] txBit   = 20'(txCnt_q / BitCyc);                // Bit slot within the reply.
   wire  [19:0] txPhase = 20'(txCnt_q % BitCyc);                // Position inside that slot.
   wire  [3:0]  slot    = 4'(txBit % 10);                       // Slot within the current byte.
   // The count restarts at every reply so slots line up with the start bit.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         txCnt_q <= '0;
      end else begin
         txCnt_q <= slaveTxEn ? txCnt_q + 20'h1 : 20'h0;
      end
   end
   // Saturates so a long quiet spell cannot wrap and look like fresh traffic.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idleCnt_q <= 11'h7ff;
      end else if (masterTxEn) begin
         idleCnt_q <= '0;
      end else if (idleCnt_q != 11'h7ff) begin
         idleCnt_q <= idleCnt_q + 11'h1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_SLAVE_START: assert property ($rose(slaveTxEn) |-> !slaveTx)
      else $error("slave reply does not open with a start bit");
   AST_MASTER_START: assert property ($rose(masterTxEn) |-> !masterTx)
      else $error("master frame does not open with a start bit");
   AST_BIT_TIMING: assert property (slaveTxEn && $past(slaveTxEn) && (slaveTx != $past(slaveTx)) |-> txPhase == 0)
      else $error("slave bit edge off the bit grid");
   AST_STOP_SLOT: assert property (slaveTxEn && slot == 4'd9 |-> slaveTx)
      else $error("slave stop bit not high");
   AST_START_SLOT: assert property (slaveTxEn && slot == 4'd0 |-> !slaveTx)
      else $error("slave start bit not low");
   AST_HEADER: assert property (slaveTxEn && txBit >= 20'd1 && txBit <= 20'd8 |-> slaveTx == HdrFirst[3'(txBit - 20'd1)])
      else $error("first header byte wrong");
   AST_HEADER2: assert property (slaveTxEn && txBit >= 20'd11 && txBit <= 20'd18 |-> slaveTx == HdrSecond[3'(txBit - 20'd11)])
      else $error("second header byte wrong");
   AST_FRAME_LEN: assert property ($fell(slaveTxEn) |-> txCnt_q == Len7 || txCnt_q == Len8)
      else $error("slave reply length wrong");
   AST_REPLY_CAUSE: assert property ($rose(slaveTxEn) |-> idleCnt_q <= 11'd4)
      else $error("slave spoke without a frame just before");
   AST_NO_CONTENTION: assert property (!(slaveTxEn && masterTxEn))
      else $error("both ends drive the pair at once");
   AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n |-> !slaveTxEn && !masterTxEn)
      else $error("pair driven during reset");
endmodule
`default_nettype wire

// ==== tb_ultrasonic_rs485_command_slave.sv ====
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_ultrasonic_rs485_command_slave
   import sonar_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BitCyc = 16;        // Shortened bit period keeps the run brief.
   localparam int MeasW  = 200;       // Shortened settle time.
   localparam int BlinkW = 50;        // Shortened blink phase.
   logic       clk_sys, rst_n, reqValid, reqReady, rspValid, measStart, measDone, measOk, tempOk, commLed;
   logic [7:0] reqAddr, reqCmd, reqArg, rspByte, nodeAddr;
   logic [8:0] measCm;
   logic [15:0] tempCode;
   int         n_fail, tests_run, ledRises, starts, tx2Rises;
   logic [7:0] rxQ[$];                // Reply bytes seen by the master.
   rs485_link_if link();
   rs485_link_if link2();             // Second pair, driven by hand with two faulty frames and one clean one.
   sonar_slave #(.LegacyBaud(1'b1), .BitLen(BitCyc), .MeasWait(MeasW), .BlinkLen(BlinkW)) u_sonar_slave (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(link.slave), .measStart(measStart), .measDone(measDone),
      .measOk(measOk), .measCm(measCm), .tempOk(tempOk), .tempCode(tempCode), .commLed(commLed), .nodeAddr(nodeAddr));
   sonar_slave #(.LegacyBaud(1'b1), .BitLen(BitCyc), .MeasWait(MeasW), .BlinkLen(BlinkW)) u_sonar_slave_b (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(link2.slave), .measStart(), .measDone(measDone),
      .measOk(measOk), .measCm(measCm), .tempOk(tempOk), .tempCode(tempCode), .commLed(), .nodeAddr());
   sonar_master #(.LegacyBaud(1'b1), .BitLen(BitCyc)) u_sonar_master (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(link.master), .reqValid(reqValid), .reqReady(reqReady),
      .reqAddr(reqAddr), .reqCmd(reqCmd), .reqArg(reqArg), .rspValid(rspValid), .rspByte(rspByte));
   sonar_link_sva #(.LegacyBaud(1'b1), .BitLen(BitCyc)) u_sonar_link_sva (
      .clk_sys(clk_sys), .rst_n(rst_n), .line(link.line), .slaveTx(link.slaveTx), .slaveTxEn(link.slaveTxEn),
      .masterTx(link.masterTx), .masterTxEn(link.masterTxEn));
   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Collects reply bytes as the master hands them out.
   always @(posedge clk_sys) begin
      if (rspValid === 1'b1) rxQ.push_back(rspByte);
   end
   // Counts indicator flashes and slave activity on the faulty pair.
   always @(posedge commLed) ledRises++;
   always @(posedge link2.slaveTxEn) tx2Rises++;
   // Front end: finishes each ranging run well inside the settle window.
   always @(posedge clk_sys) begin
      if (measStart === 1'b1) begin
         starts++;
         repeat (20) @(negedge clk_sys);
         measDone = 1'b1;
         @(negedge clk_sys);
         measDone = 1'b0;
      end
   end
   // Common end of the run, also used by the watchdog.
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One command through the master; the expected reply is built here, checksum included.
   task automatic xact(input logic [7:0] a, c, g, input int n, input logic [7:0] ra, p0, p1);
      logic [7:0] e[$];
      logic [7:0] s;
      int         t;
      rxQ.delete();
      t = 0;
      @(negedge clk_sys);
      reqAddr = a;
      reqCmd = c;
      reqArg = g;
      reqValid = 1'b1;
      while (reqReady !== 1'b1 && t < 1000) begin
         @(negedge clk_sys);
         t++;
      end
      `CHK(reqReady, 1'b1)
      @(negedge clk_sys);
      reqValid = 1'b0;
      if (n > 0) begin
         e = '{8'h55, 8'haa, ra, 8'(n - 6), c, p0};
         if (n == 8) e.push_back(p1);
         s = '0;
         foreach (e[i]) s += e[i];
         e.push_back(s);
      end
      t = 0;
      // A silent case waits long enough for a reply that must not come.
      while ((rxQ.size() < e.size() || (n == 0 && t < 90 * BitCyc)) && t < 200 * BitCyc) begin
         @(negedge clk_sys);
         t++;
      end
      repeat (3 * BitCyc) @(negedge clk_sys);
      `CHK(rxQ.size(), e.size())
      foreach (e[i]) `CHK(rxQ[i], e[i])
   endtask
   // Bit-bangs raw bytes, LSB first with start and stop bits, on the second pair.
   task automatic rawFrame(input logic [7:0] b[$]);
      link2.masterTxEn = 1'b1;
      foreach (b[i]) for (int k = 0; k < 10; k++) begin
         link2.masterTx = (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[i][k-1];
         repeat (BitCyc) @(negedge clk_sys);
      end
      link2.masterTxEn = 1'b0;
      link2.masterTx = 1'b1;
      repeat (20 * BitCyc) @(negedge clk_sys);
   endtask
   // Main sequence.
   initial begin
      int         cmTab[4] = '{301, 4, 300, 4};
      bit         okTab[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
      logic [15:0] ed;
      {rst_n, reqValid, reqAddr, reqCmd, reqArg, measDone, measCm} = '0;
      {measOk, tempOk, tempCode} = {2'b11, 16'hf00a};
      {link2.masterTx, link2.masterTxEn} = 2'b10;
      {n_fail, tests_run, ledRises, starts, tx2Rises} = '0;
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      `CHK(nodeAddr, 8'h11)
      repeat (10 * BlinkW) @(negedge clk_sys);
      `CHK(ledRises, 4)
      xact(8'h11, CmdReadDist, 8'h00, 8, 8'h11, 8'hff, 8'hff);
      xact(8'h11, CmdReadTemp, 8'h00, 8, 8'h11, 8'hf0, 8'h0a);
      `CHK(ledRises > 4, 1'b1)
      tempOk = 1'b0;
      xact(8'h11, CmdReadTemp, 8'h00, 8, 8'h11, 8'hff, 8'hff);
      // Range edges and a failed run, each read after its own trigger.
      for (int i = 0; i < 4; i++) begin
         measCm = 9'(cmTab[i]);
         measOk = okTab[i];
         ed = (okTab[i] && cmTab[i] >= 4 && cmTab[i] <= 300) ? 16'(cmTab[i]) : 16'hffff;
         xact(8'h11, CmdTrigger, 8'h00, 0, 8'h00, 8'h00, 8'h00);
         `CHK(starts, i + 1)
         repeat (MeasW) @(negedge clk_sys);
         xact(8'h11, CmdReadDist, 8'h00, 8, 8'h11, ed[15:8], ed[7:0]);
      end
      xact(8'h11, CmdSetAddr, 8'h81, 0, 8'h00, 8'h00, 8'h00);
      `CHK(nodeAddr, 8'h11)
      xact(8'h11, CmdSetAddr, 8'h80, 7, 8'h80, StatusOk, 8'h00);
      `CHK(nodeAddr, 8'h80)
      xact(8'h11, CmdReadTemp, 8'h00, 0, 8'h00, 8'h00, 8'h00);
      xact(8'h80, CmdReadDist, 8'h00, 8, 8'h80, 8'h00, 8'h04);
      // Faulty frames must be ignored; the clean one proves the path works.
      rawFrame('{8'h55, 8'hab, 8'h11, 8'h00, 8'h03, 8'h14});
      rawFrame('{8'h55, 8'haa, 8'h11, 8'h00, 8'h03, 8'h14});
      `CHK(tx2Rises, 0)
      rawFrame('{8'h55, 8'haa, 8'h11, 8'h00, 8'h03, 8'h13});
      `CHK(tx2Rises, 1)
      finish_test();
   end
   // Watchdog sized well above the expected length of the run.
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail++;
      finish_test();
   end
endmodule
`default_nettype wire
